// ==== wfsp_pkg.sv ====
package wfsp_pkg;

  // ----------------------------------------------------------------
  // Transform size and rates
  // ----------------------------------------------------------------
  localparam int NPTS = 1024;
  localparam int LOG2N = 10;
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_MHZ = 100;
  localparam int KB_ALPHA = 3;
  localparam int TRIG_AMP = 32767;
  localparam int KB_AMP = 65535;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_IN_FIFO = 4'h0;
  localparam logic [3:0] IDX_OUT_FIFO = 4'h1;
  localparam logic [3:0] IDX_CNT_LO = 4'h2;
  localparam logic [3:0] IDX_CNT_HI = 4'h3;
  localparam logic [3:0] IDX_CTRL = 4'h4;
  localparam logic [3:0] IDX_DDS0 = 4'h5;
  localparam logic [3:0] IDX_DDS1 = 4'h6;
  localparam logic [3:0] IDX_DDS2 = 4'h7;
  localparam logic [3:0] IDX_DDS3 = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_WIN_BIT = 2;
  localparam int CTRL_FWD_BIT = 3;
  localparam int STAT_PEND_BIT = 2;
  localparam int STAT_DONE_LSB = 16;
  localparam logic [1:0] SRC_ADC = 2'h0;
  localparam logic [1:0] SRC_DDS = 2'h1;
  localparam logic [1:0] SRC_MEM = 2'h2;
  localparam logic [1:0] SRC_ADC2 = 2'h3;
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [25:0] DDS_STEP_RST = 26'h666666;
  localparam logic [15:0] RECT_COEF = 16'hFFFF;

  typedef struct packed {
    logic signed [15:0] q;
    logic signed [15:0] i;
  } wfsp_sample_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_CALC = 2'b01,
    ST_SEND = 2'b10
  } wfsp_state_e;

  // Cosine or sine of 2*pi*k/NPTS, full scale
  function automatic logic [15:0] trigVal(input int k, input bit sine);
    real a;
    a = 6.283185307179586 * k / NPTS;
    return 16'($rtoi(TRIG_AMP * (sine ? $sin(a) : $cos(a))));
  endfunction

  // Modified Bessel function of order zero
  function automatic real besselI0(input real x);
    real s;
    real t;
    s = 1.0;
    t = 1.0;
    for (int k = 1; k < 30; k++)
    begin
      t = t * (x / (2.0 * k)) * (x / (2.0 * k));
      s = s + t;
    end
    return s;
  endfunction

  // Kaiser-Bessel shading coefficient for point n
  function automatic logic [15:0] kbVal(input int n);
    real p;
    real r;
    p = 3.141592653589793 * KB_ALPHA;
    r = 2.0 * n / (NPTS - 1) - 1.0;
    return 16'($rtoi(KB_AMP * besselI0(p * $sqrt(1.0 - r * r)) / besselI0(p)));
  endfunction

endpackage

// ==== wfsp_top.sv ====
`timescale 1ns/1ps
// Contract
// R1: Converter source drives quadrature input with zero
// R2: 1024 points, first is DC, natural order
// R3: Words carry in-phase low, quadrature high
// R4: Kaiser-Bessel alpha 3 table in ROM
// R5: Host loads memory source, device replays it
// R6: Samples enter at 100 MHz rate
// R7: Output words reusable as memory input
// R8: Control bits 1:0 select source, 11 converter
// R9: Rectangular window uses coefficient 0xFFFF
// R10: Write to count high starts point transfer
module wfsp_top #(
  parameter int ADC_BITS = 12
)(
  input logic clk_sys,
  input logic reset,
  input logic [5:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic [ADC_BITS-1:0] adcData,
  input logic [31:0] hostInData,
  input logic hostInValid,
  output logic hostInReady,
  output logic [31:0] outData,
  output logic outValid,
  input logic outReady
);

  if (ADC_BITS < 2 || ADC_BITS > 15)
  begin : gBadAdc
    $error("ADC_BITS must lie in 2..15");
  end

  logic [7:0] ctrlReg, inFifoReg, outFifoReg, cntLoReg;
  logic [1:0] cntHiReg;
  logic [25:0] ddsStepReg, ddsPhase;
  logic [3:0] regIdx;
  logic busReq, wrHit, pendReq, sampleEn, startSend;
  logic [31:0] rdMux;
  logic [7:0] rateAcc;
  logic [8:0] rateSum;
  logic [ADC_BITS-1:0] adcMeta, adcSync;
  logic signed [15:0] cosTab [wfsp_pkg::NPTS];
  logic signed [15:0] sinTab [wfsp_pkg::NPTS];
  logic [15:0] kbTab [wfsp_pkg::NPTS];
  logic [31:0] memRam [wfsp_pkg::NPTS];
  wfsp_pkg::wfsp_sample_s fftRam [wfsp_pkg::NPTS];
  logic [9:0] memWrPtr, loadIdx, sendIdx, mask, half, i0, i1;
  logic [10:0] sendLeft;
  logic [3:0] stage;
  logic [8:0] bfIdx, twk;
  logic [15:0] doneCnt, coef;
  wfsp_pkg::wfsp_state_e state;
  logic signed [15:0] srcI, srcQ, winI, winQ, wr, wi;
  logic signed [32:0] prodI, prodQ, trFull, tiFull;
  logic signed [17:0] sum0R, sum0I, sum1R, sum1I;
  wfsp_pkg::wfsp_sample_s bfA, bfB;

  // ----------------------------------------------------------------
  // Constant tables
  // ----------------------------------------------------------------
  // Shared cosine/sine ROM for the synthesiser and the twiddles
  for (genvar gi = 0; gi < wfsp_pkg::NPTS; gi++)
  begin : gRom
    assign cosTab[gi] = wfsp_pkg::trigVal(gi, 1'b0);
    assign sinTab[gi] = wfsp_pkg::trigVal(gi, 1'b1);
    assign kbTab[gi] = wfsp_pkg::kbVal(gi); // see R4
  end

  function automatic logic [9:0] bitRev(input logic [9:0] v);
    for (int b = 0; b < 10; b++)
      bitRev[b] = v[9 - b];
  endfunction

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  assign regIdx = avs_address[5:2];
  assign busReq = (avs_read || avs_write) && avs_waitrequest;
  assign wrHit = avs_write && !avs_waitrequest && avs_byteenable[0];

  // One wait state, then the answer stands for one cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else if (busReq)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rdMux : 32'h0;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // Read decode; unmapped indexes read zero
  always_comb
  begin
    rdMux = 32'h0;
    case (regIdx)
      wfsp_pkg::IDX_IN_FIFO: rdMux[7:0] = inFifoReg;
      wfsp_pkg::IDX_OUT_FIFO: rdMux[7:0] = outFifoReg;
      wfsp_pkg::IDX_CNT_LO: rdMux[7:0] = cntLoReg;
      wfsp_pkg::IDX_CNT_HI: rdMux[1:0] = cntHiReg;
      wfsp_pkg::IDX_CTRL: rdMux[7:0] = ctrlReg;
      wfsp_pkg::IDX_DDS0: rdMux[7:0] = ddsStepReg[7:0];
      wfsp_pkg::IDX_DDS1: rdMux[7:0] = ddsStepReg[15:8];
      wfsp_pkg::IDX_DDS2: rdMux[7:0] = ddsStepReg[23:16];
      wfsp_pkg::IDX_DDS3: rdMux[1:0] = ddsStepReg[25:24];
      wfsp_pkg::IDX_STATUS:
      begin
        rdMux[1:0] = state;
        rdMux[wfsp_pkg::STAT_PEND_BIT] = pendReq;
        rdMux[wfsp_pkg::STAT_DONE_LSB +: 16] = doneCnt;
      end
      default: rdMux = 32'h0;
    endcase
  end

  // Configuration writes, low byte lane only
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrlReg <= wfsp_pkg::CTRL_RST;
      inFifoReg <= 8'h0;
      outFifoReg <= 8'h0;
      cntLoReg <= 8'h0;
      cntHiReg <= 2'h0;
      ddsStepReg <= wfsp_pkg::DDS_STEP_RST;
    end
    else if (wrHit)
    begin
      case (regIdx)
        wfsp_pkg::IDX_IN_FIFO: inFifoReg <= avs_writedata[7:0];
        wfsp_pkg::IDX_OUT_FIFO: outFifoReg <= avs_writedata[7:0];
        wfsp_pkg::IDX_CNT_LO: cntLoReg <= avs_writedata[7:0];
        wfsp_pkg::IDX_CNT_HI: cntHiReg <= avs_writedata[1:0];
        wfsp_pkg::IDX_CTRL: ctrlReg <= avs_writedata[7:0];
        wfsp_pkg::IDX_DDS0: ddsStepReg[7:0] <= avs_writedata[7:0];
        wfsp_pkg::IDX_DDS1: ddsStepReg[15:8] <= avs_writedata[7:0];
        wfsp_pkg::IDX_DDS2: ddsStepReg[23:16] <= avs_writedata[7:0];
        wfsp_pkg::IDX_DDS3: ddsStepReg[25:24] <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // Transfer request; a new request wins over its own clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pendReq <= 1'b0;
    else if (wrHit && regIdx == wfsp_pkg::IDX_CNT_HI)
      pendReq <= 1'b1; // see R10
    else if (startSend)
      pendReq <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sample sources and window
  // ----------------------------------------------------------------
  // Fractional divider: 100 of every 250 cycles carry a sample
  assign rateSum = 9'(rateAcc) + 9'(wfsp_pkg::SAMPLE_MHZ);
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rateAcc <= 8'h0;
      sampleEn <= 1'b0;
    end
    else
    begin
      sampleEn <= rateSum >= 9'(wfsp_pkg::CLK_MHZ); // see R6
      rateAcc <= (rateSum >= 9'(wfsp_pkg::CLK_MHZ))
        ? 8'(rateSum - 9'(wfsp_pkg::CLK_MHZ)) : rateSum[7:0];
    end
  end

  // Converter pins pass two flops; synthesiser phase steps per sample
  always_ff @(posedge clk_sys)
  begin
    adcMeta <= adcData;
    adcSync <= adcMeta;
    if (reset)
      ddsPhase <= 26'h0;
    else if (sampleEn)
      ddsPhase <= ddsPhase + ddsStepReg;
  end

  // Host words fill the memory source in arrival order
  always_ff @(posedge clk_sys)
  begin
    if (hostInValid && hostInReady)
      memRam[memWrPtr] <= hostInData; // see R5
    if (reset)
    begin
      memWrPtr <= 10'h0;
      hostInReady <= 1'b0;
    end
    else
    begin
      hostInReady <= 1'b1;
      if (hostInValid && hostInReady)
        memWrPtr <= memWrPtr + 10'h1;
    end
  end

  // Source select
  always_comb
  begin
    srcI = 16'h0;
    srcQ = 16'h0;
    unique case (ctrlReg[1:0]) // see R8
      wfsp_pkg::SRC_DDS:
      begin
        srcI = cosTab[ddsPhase[25:16]];
        srcQ = sinTab[ddsPhase[25:16]];
      end
      wfsp_pkg::SRC_MEM:
      begin
        srcI = memRam[loadIdx][15:0]; // see R3, R7
        srcQ = memRam[loadIdx][31:16];
      end
      wfsp_pkg::SRC_ADC, wfsp_pkg::SRC_ADC2:
      begin
        srcI = {adcSync, {(16 - ADC_BITS){1'b0}}};
        srcQ = 16'h0; // see R1
      end
    endcase
  end

  // Window multiplier: signed sample times unsigned coefficient
  assign coef = ctrlReg[wfsp_pkg::CTRL_WIN_BIT]
    ? wfsp_pkg::RECT_COEF : kbTab[loadIdx]; // see R9, R4
  assign prodI = srcI * $signed({1'b0, coef});
  assign prodQ = srcQ * $signed({1'b0, coef});
  assign winI = prodI[31:16];
  assign winQ = prodQ[31:16];

  // ----------------------------------------------------------------
  // Radix-2 in-place transform engine
  // ----------------------------------------------------------------
  // Butterfly addresses and twiddle for the current stage
  assign half = 10'(11'h1 << stage);
  assign mask = half - 10'h1;
  assign i0 = ({bfIdx, 1'b0} & ~mask) | ({1'b0, bfIdx} & mask);
  assign i1 = i0 | half;
  assign twk = 9'(({1'b0, bfIdx} & mask) << (4'd9 - stage));
  assign wr = cosTab[{1'b0, twk}];
  assign wi = ctrlReg[wfsp_pkg::CTRL_FWD_BIT] ? -sinTab[{1'b0, twk}] : sinTab[{1'b0, twk}];
  assign bfA = fftRam[i0];
  assign bfB = fftRam[i1];
  assign trFull = bfB.i * wr - bfB.q * wi;
  assign tiFull = bfB.i * wi + bfB.q * wr;
  // Each stage halves the result so the 16-bit words do not wrap
  // Part-selects are unsigned, so the product is marked signed again
  assign sum0R = bfA.i + $signed(trFull[31:15]);
  assign sum0I = bfA.q + $signed(tiFull[31:15]);
  assign sum1R = bfA.i - $signed(trFull[31:15]);
  assign sum1I = bfA.q - $signed(tiFull[31:15]);
  assign startSend = state == wfsp_pkg::ST_CALC && stage == 4'(wfsp_pkg::LOG2N - 1)
    && bfIdx == 9'h1FF && pendReq;

  // Working store: bit-reversed load gives natural-order results
  always_ff @(posedge clk_sys)
  begin
    if (state == wfsp_pkg::ST_LOAD && sampleEn)
      fftRam[bitRev(loadIdx)] <= '{q: winQ, i: winI}; // see R2
    else if (state == wfsp_pkg::ST_CALC)
    begin
      fftRam[i0] <= '{q: sum0I[16:1], i: sum0R[16:1]};
      fftRam[i1] <= '{q: sum1I[16:1], i: sum1R[16:1]};
    end
  end

  // Sequencer: load 1024 samples, 10 stages, optional transfer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state <= wfsp_pkg::ST_LOAD;
      loadIdx <= 10'h0;
      stage <= 4'h0;
      bfIdx <= 9'h0;
      sendIdx <= 10'h0;
      sendLeft <= 11'h0;
      doneCnt <= 16'h0;
      outData <= 32'h0;
      outValid <= 1'b0;
    end
    else
    begin
      unique case (state)
        wfsp_pkg::ST_LOAD:
          if (sampleEn)
          begin
            loadIdx <= loadIdx + 10'h1;
            if (loadIdx == 10'h3FF) // see R2
            begin
              state <= wfsp_pkg::ST_CALC;
              stage <= 4'h0;
              bfIdx <= 9'h0;
            end
          end
        wfsp_pkg::ST_CALC:
        begin
          bfIdx <= bfIdx + 9'h1;
          if (bfIdx == 9'h1FF)
          begin
            stage <= stage + 4'h1;
            if (stage == 4'(wfsp_pkg::LOG2N - 1))
            begin
              doneCnt <= doneCnt + 16'h1;
              sendIdx <= 10'h0;
              sendLeft <= ({cntHiReg, cntLoReg} == 10'h0)
                ? 11'(wfsp_pkg::NPTS) : {1'b0, cntHiReg, cntLoReg}; // see R10
              state <= pendReq ? wfsp_pkg::ST_SEND : wfsp_pkg::ST_LOAD;
            end
          end
        end
        wfsp_pkg::ST_SEND:
          if (!outValid || outReady)
          begin
            if (sendLeft != 11'h0)
            begin
              outData <= fftRam[sendIdx]; // see R3, R7
              outValid <= 1'b1;
              sendIdx <= sendIdx + 10'h1;
              sendLeft <= sendLeft - 11'h1;
            end
            else
            begin
              outValid <= 1'b0;
              state <= wfsp_pkg::ST_LOAD;
            end
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  chk_adc_quad_zero: assert property ( // see R1
    ctrlReg[1:0] == wfsp_pkg::SRC_ADC || ctrlReg[1:0] == wfsp_pkg::SRC_ADC2 |-> winQ == 16'h0)
    else $error("quadrature not zero on converter source");
  chk_mem_replay: assert property ( // see R8
    ctrlReg[1:0] == wfsp_pkg::SRC_MEM |-> {srcQ, srcI} == memRam[loadIdx])
    else $error("memory source not replayed");
  chk_mem_fill: assert property ( // see R5
    hostInValid && hostInReady |=> memWrPtr == $past(memWrPtr) + 10'h1)
    else $error("memory write pointer did not advance");
  chk_rect_coef: assert property ( // see R9
    ctrlReg[wfsp_pkg::CTRL_WIN_BIT] |-> coef == 16'hFFFF)
    else $error("rectangular coefficient wrong");
  chk_kb_coef: assert property ( // see R4
    !ctrlReg[wfsp_pkg::CTRL_WIN_BIT] |-> coef == kbTab[loadIdx] && kbTab[0] < kbTab[512])
    else $error("shading table not applied");
  chk_rate_gap: assert property ( // see R6
    sampleEn |=> !sampleEn ##[1:2] sampleEn)
    else $error("sample enable spacing wrong");
  chk_frame_len: assert property ( // see R2
    state == wfsp_pkg::ST_LOAD && sampleEn && loadIdx == 10'h3FF
    |=> state == wfsp_pkg::ST_CALC && stage == 4'h0 && bfIdx == 9'h0)
    else $error("frame did not close after 1024 samples");
  chk_calc_end: assert property ( // see R2
    state == wfsp_pkg::ST_CALC && stage == 4'h9 && bfIdx == 9'h1FF
    |=> state != wfsp_pkg::ST_CALC)
    else $error("transform did not end after ten stages");
  chk_first_dc: assert property ( // see R2
    $rose(outValid) |-> outData == fftRam[0] && sendIdx == 10'h1)
    else $error("transfer did not start at the zero-frequency point");
  chk_count_req: assert property ( // see R10
    wrHit && regIdx == wfsp_pkg::IDX_CNT_HI |=> pendReq)
    else $error("count write did not request a transfer");
  chk_bus_answer: assert property (
    busReq |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

  cov_mem_send: cover property (
    ctrlReg[1:0] == wfsp_pkg::SRC_MEM && outValid && outReady);
  cov_inverse: cover property (
    !ctrlReg[wfsp_pkg::CTRL_FWD_BIT] && state == wfsp_pkg::ST_CALC);
  cov_send_done: cover property (
    state == wfsp_pkg::ST_SEND ##1 state == wfsp_pkg::ST_LOAD);
  cov_unmapped: cover property (busReq && avs_read && regIdx > wfsp_pkg::IDX_STATUS);

endmodule

// ==== wfsp_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host processor on the far side of the sample and result streams
// ----------------------------------------------------------------
module wfsp_host_model (
  input logic clk_sys,
  input logic reset,
  input logic stall,
  output logic [31:0] hostInData,
  output logic hostInValid,
  input logic hostInReady,
  input logic [31:0] outData,
  input logic outValid,
  output logic outReady
);
  logic [31:0] got[$];

  // Idle stream at time zero
  initial
  begin
    hostInData = 32'h0;
    hostInValid = 1'b0;
    outReady = 1'b0;
  end

  // One full memory image, in-phase low and quadrature high
  task automatic loadMemory(input logic [31:0] word);
    int n;
    n = 0;
    @(posedge clk_sys);
    hostInData <= word;
    hostInValid <= 1'b1;
    while (n < wfsp_pkg::NPTS)
    begin
      @(posedge clk_sys);
      if (hostInReady === 1'b1)
        n++;
    end
    hostInValid <= 1'b0;
    hostInData <= ~word; // Idle data is not left at the last value
  endtask

  // Result capture; words are kept as received for reuse as input
  always @(posedge clk_sys)
  begin
    if (!reset && outValid === 1'b1 && outReady)
      got.push_back(outData);
    outReady <= stall ? ~outReady : 1'b1; // Slow host holds off every other cycle
  end
endmodule

// ==== wfsp_top_bench.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the windowed transform path
// ----------------------------------------------------------------
module wfsp_top_bench;
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] wr;
    logic [31:0] rd;
  } wfsp_row_s;

  logic clk_sys;
  logic reset;
  logic stallHost;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] adcData;
  logic [31:0] hostInData;
  logic hostInValid;
  logic hostInReady;
  logic [31:0] outData;
  logic outValid;
  logic outReady;
  int nFail;
  int samplesChecked;
  int cycles;
  wfsp_row_s rows [6] = '{
    '{wfsp_pkg::IDX_CNT_LO, 8'hA5, 32'h000000A5},
    '{wfsp_pkg::IDX_DDS3, 8'hFF, 32'h00000003},
    '{wfsp_pkg::IDX_DDS0, 8'h3C, 32'h0000003C},
    '{wfsp_pkg::IDX_IN_FIFO, 8'h5A, 32'h0000005A},
    '{wfsp_pkg::IDX_CTRL, 8'hF6, 32'h000000F6},
    '{4'hC, 8'h77, 32'h00000000}};
  logic [3:0] rstIdx [7] = '{wfsp_pkg::IDX_CTRL, wfsp_pkg::IDX_DDS0, wfsp_pkg::IDX_DDS1,
    wfsp_pkg::IDX_DDS2, wfsp_pkg::IDX_DDS3, wfsp_pkg::IDX_CNT_LO, wfsp_pkg::IDX_CNT_HI};
  logic [7:0] rstVal [7] = '{8'h08, 8'h66, 8'h66, 8'h66, 8'h00, 8'h00, 8'h00};

  wfsp_top #(.ADC_BITS(12)) u_wfsp_top (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adcData(adcData),
    .hostInData(hostInData), .hostInValid(hostInValid), .hostInReady(hostInReady),
    .outData(outData), .outValid(outValid), .outReady(outReady));

  wfsp_host_model u_wfsp_host_model (
    .clk_sys(clk_sys), .reset(reset), .stall(stallHost), .hostInData(hostInData),
    .hostInValid(hostInValid), .hostInReady(hostInReady), .outData(outData),
    .outValid(outValid), .outReady(outReady));

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic reportAndStop;
    if (nFail == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      nFail++;
    end
  endtask

  // One bus cycle, held until waitrequest is seen low
  task automatic busCycle(input logic [3:0] idx, input logic wr, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Request a block of points; optionally check DC-only content
  task automatic runBlock(input logic [9:0] cnt, input int nPts, input logic [31:0] first,
    input bit doCheck);
    logic [31:0] rd;
    u_wfsp_host_model.got.delete();
    busCycle(wfsp_pkg::IDX_CNT_LO, 1'b1, {24'h0, cnt[7:0]}, rd);
    busCycle(wfsp_pkg::IDX_CNT_HI, 1'b1, {30'h0, cnt[9:8]}, rd);
    while (u_wfsp_host_model.got.size() < nPts)
      @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    if (doCheck)
    begin
      check(32'(u_wfsp_host_model.got.size()), 32'(nPts));
      check(32'(outValid), 32'h0);
      foreach (u_wfsp_host_model.got[k])
        check(u_wfsp_host_model.got[k], (k == 0) ? first : 32'h0);
    end
  endtask

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      nFail++;
      reportAndStop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    clk_sys = 1'b0;
    reset = 1'b1;
    stallHost = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    adcData = 12'h400;
    nFail = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    // Register write then read back, unmapped index included
    foreach (rows[k])
    begin
      busCycle(rows[k].idx, 1'b1, {24'h0, rows[k].wr}, rd);
      busCycle(rows[k].idx, 1'b0, 32'h0, rd);
      check(rd, rows[k].rd);
    end
    // Reset in mid-run restores the register defaults
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rstIdx[k])
    begin
      busCycle(rstIdx[k], 1'b0, 32'h0, rd);
      check(rd, {24'h0, rstVal[k]});
    end
    // Write with lane 0 disabled is ignored
    avs_byteenable <= 4'hE;
    busCycle(wfsp_pkg::IDX_CTRL, 1'b1, 32'h00000005, rd);
    avs_byteenable <= 4'hF;
    busCycle(wfsp_pkg::IDX_CTRL, 1'b0, 32'h0, rd);
    check(rd, 32'h00000008);
    // Converter source, code 00, rectangular, forward: quadrature forced to zero
    busCycle(wfsp_pkg::IDX_CTRL, 1'b1, 32'h0000000C, rd);
    runBlock(10'h004, 4, 32'h0, 1'b0);
    // 0x4000 loses one LSB in the window and one per stage (twiddle 32767/32768)
    runBlock(10'h004, 4, 32'h00003FF5, 1'b1);
    // Converter source, code 11, full 1024 points to a slow host
    busCycle(wfsp_pkg::IDX_CTRL, 1'b1, 32'h0000000F, rd);
    stallHost <= 1'b1;
    runBlock(10'h000, wfsp_pkg::NPTS, 32'h00003FF5, 1'b1);
    stallHost <= 1'b0;
    // Memory source, forward, in-phase constant
    busCycle(wfsp_pkg::IDX_CTRL, 1'b1, 32'h0000000E, rd);
    u_wfsp_host_model.loadMemory(32'h00004000);
    runBlock(10'h004, 4, 32'h0, 1'b0);
    runBlock(10'h004, 4, 32'h00003FF5, 1'b1);
    // Memory source, inverse, quadrature constant in the upper half-word
    busCycle(wfsp_pkg::IDX_CTRL, 1'b1, 32'h00000006, rd);
    u_wfsp_host_model.loadMemory(32'h20000000);
    runBlock(10'h004, 4, 32'h0, 1'b0);
    runBlock(10'h004, 4, 32'h1FF50000, 1'b1);
    // Synthesiser source, code 01, step zero: one constant full-scale sample
    for (int b = 0; b < 4; b++)
      busCycle(4'(wfsp_pkg::IDX_DDS0 + b), 1'b1, 32'h0, rd);
    busCycle(wfsp_pkg::IDX_CTRL, 1'b1, 32'h0000000D, rd);
    runBlock(10'h004, 4, 32'h0, 1'b0);
    runBlock(10'h004, 4, 32'h0, 1'b0);
    // Only the DC point carries the tone, unlike converter or memory results
    rd = u_wfsp_host_model.got[0];
    check(32'(rd inside {32'h0, 32'h00003FF5, 32'h1FF50000}), 32'h0);
    for (int k = 1; k < 4; k++)
      check(u_wfsp_host_model.got[k], 32'h0);
    reportAndStop();
  end
endmodule
